//--- sync_word_bus_width_detect.sv
// parallel configuration front end: hunts the sync word, detects bus width,
// then passes later data at the detected width to the packet processor
// assumes pins are synchronous to clk_sys and write_strobe marks one word per clock
`timescale 1ns/100ps
`include "sync_word_defines.svh"

// Functional notes
// - bus width is found from the sync pattern alone, no width input.
// - match against sync word AA 99 55 66, most significant byte first.
// - low lane AA, 99, 55, 66 on consecutive words locks narrow mode.
// - low lane 99 then 66 on the next word locks wide mode.
// - after lock all further data before config_done is taken at the detected width.
// - nothing reaches the packet processor before sync; earlier words discarded.
// - pin data is bit reversed per byte against the stream; compare accordingly.
// - after sync the stream goes on as commands mixed with configuration data.
// - after a full bitstream has configured, further data is ignored.
// - narrow bus carries byte msb on first_data_pin, lsb on pin seven.
// - wide bus reverses bits within each of its two bytes independently.
module sync_word_bus_width_detect
	import sync_word_pkg::*;
#(
	parameter int DATA_W = 16
)
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// configuration data pins, bit 0 is first_data_pin
	input wire logic [DATA_W-1:0] cfg_data_pins,
	input wire logic write_strobe,
	// end of configuration from the packet processor
	input wire logic config_done,
	// stream to the packet processor
	output logic [DATA_W-1:0] pkt_data,
	output logic pkt_valid,
	output logic pkt_wide,
	// status
	output logic sync_found,
	output logic bus_wide,
	output logic stream_closed,
	output logic [`DISCARD_CNT_W-1:0] discard_count
);

	////////////////////////////////////////////////////////////////////////////////
	// declarations

	detect_regs_type r_q;
	detect_regs_type r_d;
	logic [DATA_W-1:0] swapped;
	logic [`LANE_BITS-1:0] low_byte;
	logic [`LANE_BITS-1:0] high_byte;
	logic locked;

	////////////////////////////////////////////////////////////////////////////////
	// pin order correction

	lane_bit_swap #(
		.LANES(DATA_W / `LANE_BITS)
	) u_swap (
		.pins(cfg_data_pins),
		.stream(swapped)
	);

	assign low_byte = swapped[`LOW_LANE_LSB +: `LANE_BITS];
	assign high_byte = swapped[`HIGH_LANE_LSB +: `LANE_BITS];

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// start of a fresh hunt from one low lane byte; used in the idle state
	// and again whenever a partial match breaks, so a breaking byte that
	// itself opens a new match is not lost
	function automatic detect_state_type hunt_start(input logic [7:0] b);
		detect_state_type s;
		s = ST_HUNT;
		if (b == `SYNC_BYTE3)
		begin
			s = ST_SEEN_B3;
		end
		else if (b == `SYNC_BYTE2)
		begin
			s = ST_WIDE_SEEN_B2;
		end
		return s;
	endfunction

	// saturating count of words thrown away before sync
	function automatic logic [`DISCARD_CNT_W-1:0] bump(input logic [`DISCARD_CNT_W-1:0] c);
		logic [`DISCARD_CNT_W-1:0] n;
		n = c;
		if (c != {`DISCARD_CNT_W{1'b1}})
		begin
			n = c + `DISCARD_CNT_W'(1);
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		r_d = r_q;
		r_d.pkt_valid = 1'b0;
		unique case (r_q.state)
			ST_HUNT:
			begin
				if (write_strobe)
				begin
					// pads leave the hunt untouched
					if (low_byte != `PAD_BYTE)
					begin
						r_d.state = hunt_start(low_byte);
					end
					r_d.discard_cnt = bump(r_q.discard_cnt);
				end
			end
			ST_SEEN_B3:
			begin
				if (write_strobe)
				begin
					if (low_byte == `SYNC_BYTE2)
					begin
						r_d.state = ST_SEEN_B3B2;
					end
					else
					begin
						r_d.state = hunt_start(low_byte);
					end
					r_d.discard_cnt = bump(r_q.discard_cnt);
				end
			end
			ST_SEEN_B3B2:
			begin
				if (write_strobe)
				begin
					if (low_byte == `SYNC_BYTE1)
					begin
						r_d.state = ST_SEEN_B3B2B1;
					end
					else
					begin
						r_d.state = hunt_start(low_byte);
					end
					r_d.discard_cnt = bump(r_q.discard_cnt);
				end
			end
			ST_SEEN_B3B2B1:
			begin
				if (write_strobe)
				begin
					if (low_byte == `SYNC_BYTE0)
					begin
						r_d.state = ST_LOCK_NARROW;
						r_d.pkt_wide = 1'b0;
					end
					else
					begin
						r_d.state = hunt_start(low_byte);
						r_d.discard_cnt = bump(r_q.discard_cnt);
					end
				end
			end
			ST_WIDE_SEEN_B2:
			begin
				// upper lane carries the other sync bytes and is not checked
				if (write_strobe)
				begin
					if (low_byte == `SYNC_BYTE0)
					begin
						r_d.state = ST_LOCK_WIDE;
						r_d.pkt_wide = 1'b1;
					end
					else
					begin
						r_d.state = hunt_start(low_byte);
						r_d.discard_cnt = bump(r_q.discard_cnt);
					end
				end
			end
			ST_LOCK_NARROW:
			begin
				if (config_done)
				begin
					r_d.state = ST_CLOSED;
				end
				else if (write_strobe)
				begin
					// one stream byte per word, upper pins ignored
					r_d.pkt_data = {{(DATA_W - `LANE_BITS){1'b0}}, low_byte};
					r_d.pkt_valid = 1'b1;
				end
			end
			ST_LOCK_WIDE:
			begin
				if (config_done)
				begin
					r_d.state = ST_CLOSED;
				end
				else if (write_strobe)
				begin
					// upper lane holds the earlier stream byte
					r_d.pkt_data = {high_byte, low_byte};
					r_d.pkt_valid = 1'b1;
				end
			end
			ST_CLOSED:
			begin
				// no way out but reset: later bitstreams must not restart the load
				r_d.state = ST_CLOSED;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			r_q.state <= ST_HUNT;
			r_q.pkt_data <= `PKT_DATA_RST;
			r_q.pkt_valid <= 1'b0;
			r_q.pkt_wide <= 1'b0;
			r_q.discard_cnt <= `DISCARD_CNT_RST;
		end
		else
		begin
			r_q <= r_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign locked = (r_q.state == ST_LOCK_NARROW) || (r_q.state == ST_LOCK_WIDE);

	assign pkt_data = r_q.pkt_data;
	assign pkt_valid = r_q.pkt_valid;
	assign pkt_wide = r_q.pkt_wide;
	assign sync_found = locked || (r_q.state == ST_CLOSED);
	assign bus_wide = r_q.pkt_wide;
	assign stream_closed = (r_q.state == ST_CLOSED);
	assign discard_count = r_q.discard_cnt;

endmodule // sync_word_bus_width_detect

//--- sync_word_defines.svh
// constants for the sync word hunter and bus width detector
// assumes nothing of its includer: macros only, guarded against double inclusion
`ifndef SYNC_WORD_DEFINES_SVH
`define SYNC_WORD_DEFINES_SVH

// sync word bytes, most significant first, in stream (unswapped) order
`define SYNC_BYTE3 8'hAA
`define SYNC_BYTE2 8'h99
`define SYNC_BYTE1 8'h55
`define SYNC_BYTE0 8'h66
`define SYNC_WORD 32'hAA995566

// pad byte seen before the sync word
`define PAD_BYTE 8'hFF

// lane layout of the parallel data pins
`define LANE_BITS 8
`define LOW_LANE_LSB 0
`define HIGH_LANE_LSB 8

// reset values
`define PKT_DATA_RST 16'h0000
`define DISCARD_CNT_W 16
`define DISCARD_CNT_RST 16'h0000

`endif

//--- sync_word_pkg.sv
// types shared by the sync word detector and its byte swap helper
// assumes sync_word_defines.svh is on the include path
package sync_word_pkg;
`include "sync_word_defines.svh"

	typedef enum logic [2:0] {
		ST_HUNT,
		ST_SEEN_B3,
		ST_SEEN_B3B2,
		ST_SEEN_B3B2B1,
		ST_WIDE_SEEN_B2,
		ST_LOCK_NARROW,
		ST_LOCK_WIDE,
		ST_CLOSED
	} detect_state_type;

	typedef struct packed {
		detect_state_type state;
		logic [15:0] pkt_data;
		logic pkt_valid;
		logic pkt_wide;
		logic [`DISCARD_CNT_W-1:0] discard_cnt;
	} detect_regs_type;

endpackage

//--- lane_bit_swap.sv
// reverses bit order inside each byte lane of a parallel data bus
// assumes pin 0 of every lane carries that byte's most significant bit
`timescale 1ns/100ps
`include "sync_word_defines.svh"

module lane_bit_swap
	import sync_word_pkg::*;
#(
	parameter int LANES = 2
)
(
	// pin side
	input wire logic [LANES*`LANE_BITS-1:0] pins,
	// stream side
	output logic [LANES*`LANE_BITS-1:0] stream
);

	always_comb
	begin
		for (int l = 0; l < LANES; l++)
		begin
			for (int b = 0; b < `LANE_BITS; b++)
			begin
				stream[l*`LANE_BITS + b] = pins[l*`LANE_BITS + (`LANE_BITS - 1 - b)];
			end
		end
	end

endmodule // lane_bit_swap

//--- config_source.sv
// source model: puts stream bytes on the pins, bit swapped per lane
// assumes send and word change at the falling edge
`timescale 1ns/100ps
module config_source
(
	// bench side
	input wire logic clk_sys,
	input wire logic send,
	input wire logic [15:0] word,
	// pin side
	output logic [15:0] cfg_data_pins,
	output logic write_strobe
);
	logic [15:0] last_q = 16'h0000;
	function automatic logic [7:0] rev(input logic [7:0] b);
		return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
	endfunction
	// idle pins invert, so a stale word never passes
	assign cfg_data_pins = send ? {rev(word[15:8]), rev(word[7:0])} : ~last_q;
	assign write_strobe = send;
	always @(posedge clk_sys)
	begin
		last_q <= cfg_data_pins;
	end
endmodule // config_source

//--- sync_word_properties.sv
// port assertions for the width detector
// assumes binding onto the detector by port name
`timescale 1ns/100ps
`include "sync_word_defines.svh"
module sync_word_properties
#(
	parameter int DATA_W = 16
)
(
	// clock, reset, pins
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [DATA_W-1:0] cfg_data_pins,
	input wire logic write_strobe,
	input wire logic config_done,
	// stream and status
	input wire logic [DATA_W-1:0] pkt_data,
	input wire logic pkt_valid,
	input wire logic pkt_wide,
	input wire logic sync_found,
	input wire logic bus_wide,
	input wire logic stream_closed,
	input wire logic [`DISCARD_CNT_W-1:0] discard_count
);
	logic locked;
	logic [7:0] lo;
	assign locked = sync_found && !stream_closed;
	assign lo = cfg_data_pins[7:0];
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	function automatic logic [7:0] rev(input logic [7:0] b);
		return {b[0], b[1], b[2], b[3], b[4], b[5], b[6], b[7]};
	endfunction
	a_no_early_pkt: assert property
		(pkt_valid |-> $past(locked)) else $error("early pkt");
	a_locked_takes: assert property
		(locked && write_strobe && !config_done |=> pkt_valid) else $error("word lost");
	a_narrow_lane: assert property
		(pkt_valid && !pkt_wide |-> pkt_data == {8'h00, rev($past(lo))}) else $error("narrow");
	a_wide_lanes: assert property
		(pkt_valid && pkt_wide |-> pkt_data == {rev($past(cfg_data_pins[15:8])), rev($past(lo))})
		else $error("wide");
	a_lock_on_66: assert property
		($rose(sync_found) |-> $past(write_strobe && lo == 8'h66)) else $error("lock");
	a_width_frozen: assert property
		(sync_found |=> sync_found && $stable(bus_wide)) else $error("width");
	a_pad_counted: assert property
		(!sync_found && write_strobe && lo == 8'hFF && discard_count != 16'hFFFF
		|=> !sync_found && discard_count == $past(discard_count) + 16'h0001) else $error("pad");
	a_done_closes: assert property
		(locked && config_done |=> stream_closed [*4]) else $error("close");
	c_narrow: cover property ($rose(sync_found) && !bus_wide);
	c_wide: cover property ($rose(bus_wide));
	c_closed: cover property ($rose(stream_closed));
endmodule // sync_word_properties
bind sync_word_bus_width_detect sync_word_properties #(.DATA_W(DATA_W)) props (
	.clk_sys(clk_sys),
	.nrst(nrst),
	.cfg_data_pins(cfg_data_pins),
	.write_strobe(write_strobe),
	.config_done(config_done),
	.pkt_data(pkt_data),
	.pkt_valid(pkt_valid),
	.pkt_wide(pkt_wide),
	.sync_found(sync_found),
	.bus_wide(bus_wide),
	.stream_closed(stream_closed),
	.discard_count(discard_count)
);

//--- test_sync_word_bus_width_detect.sv
// bench: narrow then wide sync, data at width, closing
// assumes config_source on the pins, checker bound in
`timescale 1ns/100ps
`include "sync_word_defines.svh"
module test_sync_word_bus_width_detect;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic send = 1'b0;
	logic config_done = 1'b0;
	logic [15:0] word = 16'h0000;
	logic [15:0] cfg_data_pins, pkt_data;
	logic write_strobe, pkt_valid, pkt_wide, sync_found, bus_wide, stream_closed;
	logic [`DISCARD_CNT_W-1:0] discard_count;
	logic [31:0] seed = 32'h89B0;
	logic [15:0] s [$];
	int num_errors = 0;
	int samples_checked = 0;
	initial forever #2.5 clk_sys = ~clk_sys;
	config_source src (
		.clk_sys(clk_sys),
		.send(send),
		.word(word),
		.cfg_data_pins(cfg_data_pins),
		.write_strobe(write_strobe)
	);
	sync_word_bus_width_detect uut (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.cfg_data_pins(cfg_data_pins),
		.write_strobe(write_strobe),
		.config_done(config_done),
		.pkt_data(pkt_data),
		.pkt_valid(pkt_valid),
		.pkt_wide(pkt_wide),
		.sync_found(sync_found),
		.bus_wide(bus_wide),
		.stream_closed(stream_closed),
		.discard_count(discard_count)
	);
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic [15:0] exp_pkt(input logic [15:0] w, input logic wide);
		return wide ? w : {8'h00, w[7:0]};
	endfunction
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task summarize;
		if (num_errors == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// one word per call; the next call still lands on the next cycle
	task put(input logic [15:0] w, input logic done);
		@(negedge clk_sys);
		send <= 1'b1;
		word <= w;
		config_done <= done;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic run(input logic wide);
		@(negedge clk_sys);
		nrst <= 1'b0;
		send <= 1'b0;
		repeat (2) @(negedge clk_sys);
		nrst <= 1'b1;
		check("discards", 16'h0000, discard_count);
		if (wide)
			s = '{16'hFFFF, 16'h1299, 16'h0013, 16'hAA99, 16'h5566};
		else
			s = '{16'hFFFF, 16'h00FF, 16'h00AA, 16'h0014, 16'h00AA, 16'h0099, 16'h0055,
				16'h00AA, 16'h0099, 16'h0055, 16'h0066};
		foreach (s[i])
		begin
			if (i == s.size() - 1)
			begin
				@(negedge clk_sys) send <= 1'b0;
				check("sync", 1'b0, sync_found);
			end
			put(s[i], 1'b0);
		end
		check("sync", 1'b1, sync_found);
		check("wide", wide, bus_wide);
		check("pkt_wide", wide, pkt_wide);
		check("discards", 16'(s.size() - 1), discard_count);
		repeat (6)
		begin
			seed = xorshift(seed);
			put(seed[15:0], 1'b0);
			check("valid", 1'b1, pkt_valid);
			check("data", exp_pkt(seed[15:0], wide), pkt_data);
		end
		put(16'h00AA, 1'b1);
		check("closed", 1'b1, stream_closed);
		check("valid", 1'b0, pkt_valid);
		put(16'h0099, 1'b0);
		check("valid", 1'b0, pkt_valid);
	endtask
	initial
	begin
		run(1'b0);
		run(1'b1);
		summarize();
	end
	initial
	begin
		#20000;
		num_errors++;
		summarize();
	end
endmodule // test_sync_word_bus_width_detect
